// ---- ohf_pkg.sv ----
// Purpose: Constants and carrier types for the overheat pin and fan sync block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register offsets are word indexes; byte address is four times them
package ohf_pkg;

	localparam int ADDR_W = 10;
	localparam int CLK_PERIOD_NS = 10;

	// Register indexes
	localparam logic [7:0] IDX_R1_CFG = 8'h5F;
	localparam logic [7:0] IDX_LOC_CFG = 8'h60;
	localparam logic [7:0] IDX_R2_CFG = 8'h61;
	localparam logic [7:0] IDX_ACOUSTIC = 8'h62;
	localparam logic [7:0] IDX_R1_LIM = 8'h6A;
	localparam logic [7:0] IDX_LOC_LIM = 8'h6B;
	localparam logic [7:0] IDX_R2_LIM = 8'h6C;
	localparam logic [7:0] IDX_STATUS2 = 8'h42;
	localparam logic [7:0] IDX_MASK2 = 8'h75;
	localparam logic [7:0] IDX_CFG3 = 8'h78;
	localparam logic [7:0] IDX_TIMER = 8'h79;
	localparam logic [7:0] IDX_TIMER_LIM = 8'h7A;
	localparam logic [7:0] IDX_CFG4 = 8'h7D;
	localparam logic [7:0] IDX_FAN_MODE = 8'h80;

	// Field positions
	localparam int BIT_OUT_EN = 3;
	localparam int BIT_SYNC = 4;
	localparam int BIT_TIMER_FLAG = 5;
	localparam int BIT_ALERT_EN = 0;
	localparam int BIT_TIMER_EN = 1;
	localparam int BIT_OVERRIDE = 2;
	localparam int BIT_HIGH_FREQ = 3;
	localparam int BIT_FOUR_WIRE = 4;
	localparam int BIT_TWOS_COMP = 5;
	localparam logic [1:0] PIN_FUNC_OVERHEAT = 2'h1;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_MASK2 = 8'h00;

	// Limit values that switch a channel's output off, and full fan duty
	localparam logic [7:0] LIM_OFF_OFFSET64 = 8'h00;
	localparam logic [7:0] LIM_OFF_TWOS = 8'h80;
	localparam logic [7:0] DUTY_FULL = 8'hFF;

	// Timer step of 22.76 ms
	localparam int TIMER_STEP_NS = 22760000;
	localparam int TIMER_STEP_CYC = TIMER_STEP_NS / CLK_PERIOD_NS;

	// Fan drive prescale divisors (cycles per duty step)
	localparam int PWM_HIGH_DIV = 4;
	localparam int PWM_LOW_DIV = 64;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} ohf_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ohf_apb_rsp_type;

	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [9:0] temp;
	} ohf_meas_type;

endpackage

// ---- ohf_overheat_fan.sv ----
// Purpose: Overheat pin handling, fan drive override and speed input binding
// Assumes: Measurements and duty settings come from logic on clk
// Notes: Temperatures carry two fraction bits (0.25 degree steps)
// Functional notes
// - Override and timer enable bits plus running fan give full duty while pin asserted
// - Override off keeps present duty
// - Stopped fan never forced to full
// - Mask bit suppresses timer-limit alert
// - Zero limit alerts on first assertion
// - Enabled channel over limit pulls pin
// - Pin held until temp at limit
// - Pin low at least one cycle
// - Critical limits at 0x6A, 0x6B, 0x6C
// - Bit 3 enables per-channel output
// - Lowest limit code disables channel output
// - Square wave duty, low or high
// - Four speed inputs, three drives
// - Speed input aligned to own drive
// - Inputs three, four use drive three
// - Sync bit binds two-four to three
// - High frequency four-wire needs no sync
// - Timer over limit sets sticky flag
// - Timer step 22.76 ms, clears, saturates
// - Two bits select shared pin function
module ohf_overheat_fan
	import ohf_pkg::*;
#(
	parameter int STEP_CYC = TIMER_STEP_CYC,
	parameter int HIGH_DIV = PWM_HIGH_DIV,
	parameter int LOW_DIV = PWM_LOW_DIV
)
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Register bus
	input wire ohf_pkg::ohf_apb_req_type apbReq,
	output ohf_pkg::ohf_apb_rsp_type apbRsp,
	// Measurement and duty inputs
	input wire ohf_pkg::ohf_meas_type meas,
	input wire logic [2:0][7:0] fanDuty,
	// Overheat pin, open drain
	input wire logic overheatPinIn,
	output logic overheatPinOut,
	output logic overheatPinOe,
	// Speed inputs and drives
	output logic [2:0] fanDrive,
	output logic [3:0] speedGate,
	// Alert
	output logic alertOut
);
	import ohf_pkg::*;

	localparam int SUB_W = $clog2(STEP_CYC + 1);
	localparam int PRE_W = 16;

	logic [2:0][7:0] chanCfg_q, chanCfg_d;
	logic [2:0][7:0] chanLim_q, chanLim_d;
	logic [7:0] acoustic_q, acoustic_d;
	logic [7:0] mask2_q, mask2_d;
	logic [7:0] cfg3_q, cfg3_d;
	logic [7:0] cfg4_q, cfg4_d;
	logic [7:0] timerLim_q, timerLim_d;
	logic [7:0] fanMode_q, fanMode_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic [31:0] rdata_q, rdata_d;
	logic pinMeta_q, pinSync_q;
	logic [SUB_W-1:0] sub_q, sub_d;
	logic [7:0] steps_q, steps_d;
	logic seen_q, seen_d;
	logic flag_q, flag_d;
	logic alert_q, alert_d;
	logic [2:0] over_q, over_d;
	logic pinOe_q, pinOe_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic [7:0] pwm_q, pwm_d;
	logic [2:0] drive_q, drive_d;
	logic [3:0] gate_q, gate_d;
	logic [7:0] idx;
	logic access, wrEn, rdEn, mapped;
	logic ovhFunc, asserted, twosComp;
	logic [7:0] timerView;

	assign idx = apbReq.paddr[ADDR_W-1:2];
	assign access = apbReq.psel && apbReq.penable && ready_q;
	assign wrEn = access && apbReq.pwrite;
	assign rdEn = access && !apbReq.pwrite;
	assign ovhFunc = (cfg4_q[1:0] == PIN_FUNC_OVERHEAT);
	assign asserted = ovhFunc && cfg3_q[BIT_TIMER_EN] && !pinSync_q;
	assign twosComp = fanMode_q[BIT_TWOS_COMP];
	// first assertion shows as one until steps exist
	assign timerView = (steps_q != RST_ZERO) ? steps_q : {7'h00, seen_q};

	// Address decode for reads and error answer
	always_comb
	begin
		mapped = 1'b1;
		rdata_d = rdata_q;
		unique case (idx)
			IDX_R1_CFG: rdata_d = {24'h000000, chanCfg_q[0]};
			IDX_LOC_CFG: rdata_d = {24'h000000, chanCfg_q[1]};
			IDX_R2_CFG: rdata_d = {24'h000000, chanCfg_q[2]};
			IDX_ACOUSTIC: rdata_d = {24'h000000, acoustic_q};
			IDX_R1_LIM: rdata_d = {24'h000000, chanLim_q[0]};
			IDX_LOC_LIM: rdata_d = {24'h000000, chanLim_q[1]};
			IDX_R2_LIM: rdata_d = {24'h000000, chanLim_q[2]};
			IDX_STATUS2: rdata_d = {26'h0000000, flag_q, 5'h00};
			IDX_MASK2: rdata_d = {24'h000000, mask2_q};
			IDX_CFG3: rdata_d = {24'h000000, cfg3_q};
			IDX_TIMER: rdata_d = {24'h000000, timerView};
			IDX_TIMER_LIM: rdata_d = {24'h000000, timerLim_q};
			IDX_CFG4: rdata_d = {24'h000000, cfg4_q};
			IDX_FAN_MODE: rdata_d = {24'h000000, fanMode_q};
			default:
			begin
				mapped = 1'b0;
				rdata_d = 32'h00000000;
			end
		endcase
		// Data is latched in the setup cycle; answer comes one cycle later
		if (!(apbReq.psel && !apbReq.penable))
		begin
			rdata_d = rdata_q;
		end
		ready_d = apbReq.psel && !apbReq.penable;
		// Error answer stands only alongside pready
		err_d = (apbReq.psel && !apbReq.penable) ? !mapped : 1'b0;
	end

	// Writable registers
	always_comb
	begin
		chanCfg_d = chanCfg_q;
		chanLim_d = chanLim_q;
		acoustic_d = acoustic_q;
		mask2_d = mask2_q;
		cfg3_d = cfg3_q;
		cfg4_d = cfg4_q;
		timerLim_d = timerLim_q;
		fanMode_d = fanMode_q;
		if (wrEn)
		begin
			case (idx)
				IDX_R1_CFG: chanCfg_d[0] = apbReq.pwdata[7:0];
				IDX_LOC_CFG: chanCfg_d[1] = apbReq.pwdata[7:0];
				IDX_R2_CFG: chanCfg_d[2] = apbReq.pwdata[7:0];
				IDX_ACOUSTIC: acoustic_d = apbReq.pwdata[7:0];
				IDX_R1_LIM: chanLim_d[0] = apbReq.pwdata[7:0];
				IDX_LOC_LIM: chanLim_d[1] = apbReq.pwdata[7:0];
				IDX_R2_LIM: chanLim_d[2] = apbReq.pwdata[7:0];
				IDX_MASK2: mask2_d = apbReq.pwdata[7:0];
				IDX_CFG3: cfg3_d = apbReq.pwdata[7:0];
				IDX_TIMER_LIM: timerLim_d = apbReq.pwdata[7:0];
				IDX_CFG4: cfg4_d = apbReq.pwdata[7:0];
				IDX_FAN_MODE: fanMode_d = apbReq.pwdata[7:0];
				default:
				begin
					fanMode_d = fanMode_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			chanCfg_q <= '0;
			chanLim_q <= '0;
			acoustic_q <= RST_ZERO;
			mask2_q <= RST_MASK2;
			cfg3_q <= RST_ZERO;
			cfg4_q <= RST_ZERO;
			timerLim_q <= RST_ZERO;
			fanMode_q <= RST_ZERO;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else if (clkEn)
		begin
			chanCfg_q <= chanCfg_d;
			chanLim_q <= chanLim_d;
			acoustic_q <= acoustic_d;
			mask2_q <= mask2_d;
			cfg3_q <= cfg3_d;
			cfg4_q <= cfg4_d;
			timerLim_q <= timerLim_d;
			fanMode_q <= fanMode_d;
			ready_q <= ready_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	// Pin synchroniser; own drive is seen too, as on the wire
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pinMeta_q <= 1'b1;
			pinSync_q <= 1'b1;
		end
		else if (clkEn)
		begin
			pinMeta_q <= overheatPinIn;
			pinSync_q <= pinMeta_q;
		end
	end

	// Assertion timer, sticky flag and alert
	always_comb
	begin
		sub_d = sub_q;
		steps_d = steps_q;
		seen_d = seen_q;
		if (rdEn && idx == IDX_TIMER)
		begin
			sub_d = '0;
			steps_d = RST_ZERO;
			seen_d = 1'b0;
		end
		else if (asserted)
		begin
			seen_d = 1'b1;
			if (sub_q == SUB_W'(STEP_CYC - 1))
			begin
				sub_d = '0;
				if (steps_q != 8'hFF)
				begin
					steps_d = steps_q + 8'h01;
				end
			end
			else
			begin
				sub_d = sub_q + SUB_W'(1);
			end
		end
		// a zero limit trips on first assertion
		// Set wins over the clear from reading the status register
		flag_d = flag_q;
		if (rdEn && idx == IDX_STATUS2)
		begin
			flag_d = 1'b0;
		end
		if (timerView > timerLim_q)
		begin
			flag_d = 1'b1;
		end
		// mask only gates the alert, not the flag
		alert_d = flag_d && !mask2_q[BIT_TIMER_FLAG] && cfg3_q[BIT_ALERT_EN];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sub_q <= '0;
			steps_q <= RST_ZERO;
			seen_q <= 1'b0;
			flag_q <= 1'b0;
			alert_q <= 1'b0;
		end
		else if (clkEn)
		begin
			sub_q <= sub_d;
			steps_q <= steps_d;
			seen_q <= seen_d;
			flag_q <= flag_d;
			alert_q <= alert_d;
		end
	end

	// Per-channel critical comparison
	genvar c;
	generate
		for (c = 0; c < 3; c++)
		begin : g_chan
			logic [9:0] tempKey, limKey;
			logic limOff, overNext;
			always_comb
			begin
				// Flip sign bit so both encodings compare unsigned
				tempKey = {meas.temp[9] ^ twosComp, meas.temp[8:0]};
				limKey = {chanLim_q[c][7] ^ twosComp, chanLim_q[c][6:0], 2'b00};
				limOff = twosComp ? (chanLim_q[c] == LIM_OFF_TWOS) :
					(chanLim_q[c] == LIM_OFF_OFFSET64);
				overNext = over_q[c];
				if (!chanCfg_q[c][BIT_OUT_EN] || limOff)
				begin
					overNext = 1'b0;
				end
				// update only when this channel is measured
				else if (meas.valid && meas.channel == 2'(c))
				begin
					overNext = tempKey > limKey;
				end
			end
			// One process per bit keeps a single driver on each
			assign over_d[c] = overNext;
		end
	endgenerate

	always_comb
	begin
		// state holds until next measurement of that channel
		pinOe_d = ovhFunc && (over_d != 3'b000);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			over_q <= 3'b000;
			pinOe_q <= 1'b0;
		end
		else if (clkEn)
		begin
			over_q <= over_d;
			pinOe_q <= pinOe_d;
		end
	end

	// Fan drive square wave and speed input binding
	always_comb
	begin
		logic [PRE_W-1:0] div;
		logic [7:0] duty;
		logic tick;
		div = '0;
		duty = '0;
		tick = 1'b0;
		// low frequency set by three select bits
		if (fanMode_q[BIT_HIGH_FREQ])
		begin
			div = PRE_W'(HIGH_DIV);
		end
		else
		begin
			div = PRE_W'(LOW_DIV) << fanMode_q[2:0];
		end
		tick = (pre_q >= div - PRE_W'(1));
		pre_d = tick ? '0 : pre_q + PRE_W'(1);
		pwm_d = tick ? pwm_q + 8'h01 : pwm_q;
		for (int i = 0; i < 3; i++)
		begin
			duty = fanDuty[i];
			// only a running fan is forced
			if (cfg3_q[BIT_OVERRIDE] && asserted && duty != RST_ZERO)
			begin
				duty = DUTY_FULL;
			end
			drive_d[i] = (duty == DUTY_FULL) || (pwm_q < duty);
		end
		// input one to one, two to two
		gate_d[0] = drive_q[0];
		// sync bit moves input two to drive three
		gate_d[1] = acoustic_q[BIT_SYNC] ? drive_q[2] : drive_q[1];
		// inputs three and four share drive three
		gate_d[2] = drive_q[2];
		gate_d[3] = drive_q[2];
		if (fanMode_q[BIT_HIGH_FREQ] && fanMode_q[BIT_FOUR_WIRE])
		begin
			gate_d = 4'hF;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pre_q <= '0;
			pwm_q <= RST_ZERO;
			drive_q <= 3'b000;
			gate_q <= 4'h0;
		end
		else if (clkEn)
		begin
			pre_q <= pre_d;
			pwm_q <= pwm_d;
			drive_q <= drive_d;
			gate_q <= gate_d;
		end
	end

	assign apbRsp.prdata = rdata_q;
	assign apbRsp.pready = ready_q;
	assign apbRsp.pslverr = err_q;
	// Open drain: only ever pulls low
	assign overheatPinOut = 1'b0;
	assign overheatPinOe = pinOe_q;
	assign fanDrive = drive_q;
	assign speedGate = gate_q;
	assign alertOut = alert_q;

endmodule

// ---- ohf_partner.sv ----
// Purpose: Far side of the overheat pin: a hot signal that can pull low
// Assumes: Board pull-up on the pin
// Notes: Wired-AND of both pulls
module ohf_partner
(
	// Pulls
	input wire logic extPull,
	input wire logic pinOe,
	// Wire level
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin floats up, so the last value never lingers
	assign pinLevel = !(extPull || pinOe);
endmodule

// ---- ohf_overheat_fan_monitor.sv ----
// Purpose: Port checks for the overheat and fan block
// Assumes: One clock domain, clkEn high around bus cycles
// Notes: Bound to the block after the module
module ohf_overheat_fan_monitor
	import ohf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Bus
	input wire ohf_pkg::ohf_apb_req_type apbReq,
	input wire ohf_pkg::ohf_apb_rsp_type apbRsp,
	// Inputs
	input wire ohf_pkg::ohf_meas_type meas,
	input wire logic [2:0][7:0] fanDuty,
	input wire logic overheatPinIn,
	// Outputs
	input wire logic overheatPinOut,
	input wire logic overheatPinOe,
	input wire logic [2:0] fanDrive,
	input wire logic [3:0] speedGate,
	input wire logic alertOut
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence setupS;
		apbReq.psel && !apbReq.penable && clkEn;
	endsequence
	sequence accessS;
		apbRsp.pready ##1 !apbRsp.pready;
	endsequence
	bus_ready_a: assert property (setupS |=> accessS)
		else $error("pready not one cycle after setup");
	err_with_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("pslverr outside pready");
	pin_open_drain_a: assert property (overheatPinOut == 1'b0)
		else $error("pin output level not low");
	gate_shared_a: assert property (speedGate[3] == speedGate[2])
		else $error("speed gates three and four differ");
	full_duty_a: assert property (
		clkEn && fanDuty[0] == DUTY_FULL |=> fanDrive[0])
		else $error("full duty drive not high");
	stopped_fan_a: assert property (
		clkEn && fanDuty[2] == 8'h00 |=> !fanDrive[2])
		else $error("stopped fan driven");
	pin_rise_meas_a: assert property (
		$rose(overheatPinOe) |-> $past(meas.valid))
		else $error("pin pulled without measurement");
	// Pin is released only by a new measurement or a register write
	pin_fall_cause_a: assert property ($fell(overheatPinOe) |->
		$past(meas.valid) || $past(apbRsp.pready, 2) ||
		$past(apbRsp.pready, 3) || $past(apbRsp.pready, 4))
		else $error("pin released without cause");
endmodule
bind ohf_overheat_fan ohf_overheat_fan_monitor ohf_overheat_fan_monitor_inst (
	.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .apbReq(apbReq),
	.apbRsp(apbRsp), .meas(meas), .fanDuty(fanDuty),
	.overheatPinIn(overheatPinIn), .overheatPinOut(overheatPinOut),
	.overheatPinOe(overheatPinOe), .fanDrive(fanDrive),
	.speedGate(speedGate), .alertOut(alertOut));

// ---- tb_ohf_overheat_fan.sv ----
// Purpose: Self-checking bench for the overheat and fan block
// Assumes: Short timer step and fast fan counter
// Notes: Register model is an int array
module tb_ohf_overheat_fan;
	import ohf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, clkEn, extPull, pin, pinOut, oe, alert, rerr, s, f;
	ohf_apb_req_type req;
	ohf_apb_rsp_type rsp;
	ohf_meas_type meas;
	logic [2:0][7:0] duty;
	logic [2:0] drive, d;
	logic [3:0] gate, g;
	logic [31:0] rdat;
	logic [7:0] lim;
	int err_count, n_checks, hi;
	int regs [256];
	ohf_overheat_fan #(.STEP_CYC(8), .HIGH_DIV(1), .LOW_DIV(2))
	ohf_overheat_fan_inst (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
		.apbReq(req), .apbRsp(rsp), .meas(meas), .fanDuty(duty),
		.overheatPinIn(pin), .overheatPinOut(pinOut),
		.overheatPinOe(oe), .fanDrive(drive), .speedGate(gate),
		.alertOut(alert));
	ohf_partner ohf_partner_inst (.extPull(extPull), .pinOe(oe),
		.pinLevel(pin));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end
	task chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] i, input logic [7:0] dat);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h0, dat}};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1);
		chk1(rsp.pready, 1'b1);
		// Slave answers in the first access cycle
		chk8(8'(n), 8'd1);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
		if (w)
			regs[i] = dat;
	endtask
	task rd(input logic [7:0] i, input logic [7:0] exp);
		apb(1'b0, i, 8'h00);
		chk8(rdat[7:0], exp);
	endtask
	task mchk(input logic [1:0] c, input logic [9:0] v, input logic exp);
		@(posedge clk);
		meas <= '{1'b1, c, v};
		@(posedge clk);
		meas.valid <= 1'b0;
		repeat (3) @(posedge clk);
		chk1(oe, exp);
	endtask
	task endt(input int n);
		$display("test %0d done", n);
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		extPull = 1'b0;
		req = '0;
		meas = '0;
		duty = '0;
		err_count = 0;
		n_checks = 0;
		hi = $urandom(38748);
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd(IDX_MASK2, RST_MASK2);
		for (int c = 0; c < 3; c++)
			apb(1'b1, 8'(IDX_R1_LIM + c), 8'($urandom));
		for (int c = 0; c < 3; c++)
			rd(8'(IDX_R1_LIM + c), 8'(regs[IDX_R1_LIM + c]));
		apb(1'b1, 8'h10, 8'h5A);
		rd(8'h10, 8'h00);
		chk1(rerr, 1'b1);
		endt(1);
		apb(1'b1, IDX_CFG4, 8'(PIN_FUNC_OVERHEAT));
		for (int c = 0; c < 3; c++)
		begin
			lim = 8'h41 + 8'($urandom % 62);
			apb(1'b1, 8'(IDX_R1_LIM + c), lim);
			apb(1'b1, 8'(IDX_R1_CFG + c), 8'h08);
			mchk(2'(c), {lim, 2'b01}, 1'b1);
			mchk(2'(c), {lim, 2'b00}, 1'b0);
			mchk(2'(c), {lim, 2'b01}, 1'b1);
			apb(1'b1, 8'(IDX_R1_CFG + c), 8'h00);
			mchk(2'(c), {lim, 2'b01}, 1'b0);
			apb(1'b1, 8'(IDX_R1_CFG + c), 8'h08);
			apb(1'b1, 8'(IDX_R1_LIM + c), LIM_OFF_OFFSET64);
			mchk(2'(c), 10'h3FF, 1'b0);
		end
		apb(1'b1, IDX_FAN_MODE, 8'h20);
		apb(1'b1, IDX_R1_LIM, LIM_OFF_TWOS);
		mchk(2'd0, 10'h3FF, 1'b0);
		apb(1'b1, IDX_FAN_MODE, 8'h00);
		endt(2);
		apb(1'b1, IDX_CFG3, 8'h06);
		duty <= {8'h00, 8'h01, 8'h01 + 8'($urandom % 254)};
		extPull <= 1'b1;
		repeat (4) @(posedge clk);
		hi = 0;
		repeat (16)
		begin
			@(posedge clk);
			hi += (drive === 3'b011);
		end
		chk8(8'(hi), 8'd16);
		apb(1'b1, IDX_CFG3, 8'h02);
		duty[0] <= 8'h01;
		repeat (4) @(posedge clk);
		hi = 0;
		repeat (16)
		begin
			@(posedge clk);
			hi += drive[0];
		end
		// Duty one is high two cycles out of 512
		chk1(hi <= 2, 1'b1);
		endt(3);
		apb(1'b1, IDX_CFG3, 8'h03);
		repeat (3) @(posedge clk);
		chk1(alert, 1'b1);
		rd(IDX_STATUS2, 8'h20);
		apb(1'b1, IDX_MASK2, 8'h20);
		repeat (3) @(posedge clk);
		chk1(alert, 1'b0);
		rd(IDX_STATUS2, 8'h20);
		apb(1'b0, IDX_TIMER, 8'h00);
		// timer read at a fixed interval
		repeat (40) @(posedge clk);
		apb(1'b0, IDX_TIMER, 8'h00);
		// Some 41 asserted cycles at eight per step
		chk1(rdat[7:0] >= 8'd4 && rdat[7:0] <= 8'd6, 1'b1);
		endt(4);
		extPull <= 1'b0;
		apb(1'b1, IDX_CFG3, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			d = 3'($urandom);
			s = k[0];
			// Make the sync choice visible on gate two
			if (s)
				d[1] = !d[2];
			f = (k > 3);
			duty <= {{8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
			apb(1'b1, IDX_ACOUSTIC, {3'b000, s, 4'h0});
			apb(1'b1, IDX_FAN_MODE, f ? 8'h18 : 8'h00);
			repeat (4) @(posedge clk);
			g = f ? 4'hF : {d[2], d[2], s ? d[2] : d[1], d[0]};
			chk8({4'h0, gate}, {4'h0, g});
		end
		endt(5);
		// Clock enable low must freeze the drives
		d = drive;
		clkEn <= 1'b0;
		duty <= ~duty;
		repeat (4) @(posedge clk);
		chk8({5'h00, drive}, {5'h00, d});
		clkEn <= 1'b1;
		endt(6);
		finish_test();
	end
endmodule
